// ---- cba_chk_monitor.sv ----
// Checker for register bus answers, bus-master grants and queue fault flags
`timescale 1ns/1ns
module cba_chk_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dcr_read,
  input wire logic dcr_write,
  input wire logic [9:0] dcr_addr,
  input wire logic [31:0] dcr_wdata,
  input wire logic [31:0] dcr_rdata,
  input wire logic dcr_ack,
  input wire logic [4:0] master_req,
  input wire logic master_arb_ready,
  input wire logic [4:0] master_gnt,
  input wire cba_pkg::cba_fault_t master_queue_fault_evt,
  input wire logic read_queue_reset,
  input wire logic write_queue_reset,
  input wire logic master_xbar_fifo_int
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic tk;
  logic wf;
  logic wq;
  assign tk = (dcr_read | dcr_write) & ~dcr_ack;
  assign wf = tk & dcr_write & (dcr_addr == cba_pkg::MASTER_FAULT_ADDR);
  assign wq = tk & dcr_write & (dcr_addr == cba_pkg::MASTER_RESET_CTRL_ADDR);
  ////////////////////////////////////////////////////////////////////////////
  property p_ack; tk |=> dcr_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_onehot; $onehot0(master_gnt); endproperty
  a_onehot: assert property (p_onehot) else $error("multi grant");
  property p_gnt; master_arb_ready && |master_req |=> $onehot(master_gnt); endproperty
  a_gnt: assert property (p_gnt) else $error("no grant");
  property p_idle; !(master_arb_ready && |master_req) |=> !(|master_gnt); endproperty
  a_idle: assert property (p_idle) else $error("idle grant");
  property p_gsub; |master_gnt |-> (master_gnt & ~$past(master_req)) == 5'h00; endproperty
  a_gsub: assert property (p_gsub) else $error("grant w/o req");
  property p_int; |master_queue_fault_evt |=> master_xbar_fifo_int; endproperty
  a_int: assert property (p_int) else $error("no fault int");
  property p_keep; master_xbar_fifo_int && !(wf && |dcr_wdata[3:0]) |=> master_xbar_fifo_int;
  endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  property p_rq; wq && dcr_wdata[1] |=> read_queue_reset ##1 !read_queue_reset; endproperty
  a_rq: assert property (p_rq) else $error("read reset pulse");
  property p_wq; wq && dcr_wdata[0] |=> write_queue_reset; endproperty
  a_wq: assert property (p_wq) else $error("write reset pulse");
  property p_rz; tk && dcr_read && dcr_addr == cba_pkg::MASTER_RESET_CTRL_ADDR |=> !(|dcr_rdata);
  endproperty
  a_rz: assert property (p_rz) else $error("reset ctrl read");
  c_wq: cover property (wq && dcr_wdata[0]);
  c_gnt: cover property (|master_gnt);
  c_int: cover property (master_xbar_fifo_int);
endmodule : cba_chk_monitor
////////////////////////////////////////////////////////////////////////////
bind cba_crossbar_arbiter_config cba_chk_monitor u_mon (.clk(clk), .rst_n(rst_n),
  .dcr_read(dcr_read), .dcr_write(dcr_write), .dcr_addr(dcr_addr), .dcr_wdata(dcr_wdata),
  .dcr_rdata(dcr_rdata), .dcr_ack(dcr_ack), .master_req(master_req),
  .master_arb_ready(master_arb_ready), .master_gnt(master_gnt),
  .master_queue_fault_evt(master_queue_fault_evt), .read_queue_reset(read_queue_reset),
  .write_queue_reset(write_queue_reset), .master_xbar_fifo_int(master_xbar_fifo_int));

// ---- cba_crossbar_arbiter_config.sv ----
// Crossbar arbiters with configuration, queue fault flags and queue reset controls
`timescale 1ns/1ns

module cba_crossbar_arbiter_config #(
  parameter logic [31:0] MASTER_ARBITER_INIT_ATTR = cba_pkg::ARB_CFG_DEFAULT,
  parameter logic [31:0] MEMPORT_ARBITER_INIT_ATTR = cba_pkg::ARB_CFG_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  // Device control register bus
  input wire logic dcr_read,
  input wire logic dcr_write,
  input wire logic [9:0] dcr_addr,
  input wire logic [31:0] dcr_wdata,
  output logic [31:0] dcr_rdata,
  output logic dcr_ack,
  // Bus-master crossbar arbiter
  input wire logic [4:0] master_req,
  input wire logic master_arb_ready,
  output logic [4:0] master_gnt,
  output logic attr_sync_enable,
  // Memory controller port crossbar arbiter
  input wire logic [4:0] memory_controller_port_req,
  input wire logic memory_controller_port_arb_ready,
  output logic [4:0] memory_controller_port_gnt,
  // Bus-master crossbar command queues
  input wire cba_pkg::cba_fault_t master_queue_fault_evt,
  output logic read_queue_reset,
  output logic write_queue_reset,
  output logic master_xbar_fifo_int
);

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter checks

  if ((MASTER_ARBITER_INIT_ATTR & ~cba_pkg::MASTER_CFG_MASK) != 32'h0000_0000) begin : g_chk_m
    $error("Master arbiter init value sets reserved bits");
  end
  if ((MEMPORT_ARBITER_INIT_ATTR & ~cba_pkg::MEMPORT_CFG_MASK) != 32'h0000_0000) begin : g_chk_p
    $error("Memory-port arbiter init value sets reserved bits");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [2:0] prio_of(input cba_pkg::cba_cfg_t cfg, input logic [2:0] idx);
    logic [2:0] p;
    p = 3'h0;
    case (idx)
      cba_pkg::REQ_INSTR_READ: p = cfg.instr_read_prio;
      cba_pkg::REQ_DATA_WRITE: p = cfg.data_write_prio;
      cba_pkg::REQ_DATA_READ: p = cfg.data_read_prio;
      cba_pkg::REQ_SLAVE_PORT0: p = cfg.slave_port0_prio;
      cba_pkg::REQ_SLAVE_PORT1: p = cfg.slave_port1_prio;
      default: p = 3'h0;
    endcase
    return p;
  endfunction : prio_of

  // Highest-priority active requester, optionally only those below a limit
  function automatic cba_pkg::cba_pick_t pick_prio(input logic [4:0] req,
                                                   input cba_pkg::cba_cfg_t cfg,
                                                   input logic [2:0] limit,
                                                   input logic use_limit);
    cba_pkg::cba_pick_t pk;
    logic [2:0] p;
    logic [2:0] best;
    pk = '0;
    p = 3'h0;
    best = 3'h0;
    for (int i = 0; i < cba_pkg::NUM_REQ; i++) begin
      p = prio_of(cfg, 3'(i));
      if (req[i] && (!use_limit || p < limit) && (!pk.found || p > best)) begin
        pk.found = 1'b1;
        pk.idx = 3'(i);
        best = p;
      end
    end
    return pk;
  endfunction : pick_prio

  function automatic logic [4:0] onehot(input logic [2:0] idx);
    return 5'(5'h01 << idx);
  endfunction : onehot

  // Init word is servable: priorities 0 to 4, all distinct, no reserved mode
  function automatic logic cfg_legal(input logic [31:0] word);
    cba_pkg::cba_cfg_t c;
    logic ok;
    c = cba_pkg::cba_cfg_t'(word);
    ok = (c.mode <= cba_pkg::MODE_FIXED);
    for (int i = 0; i < cba_pkg::NUM_REQ; i++) begin
      if (prio_of(c, 3'(i)) > cba_pkg::PRIO_MAX) begin
        ok = 1'b0;
      end
      for (int j = i + 1; j < cba_pkg::NUM_REQ; j++) begin
        if (prio_of(c, 3'(i)) == prio_of(c, 3'(j))) begin
          ok = 1'b0;
        end
      end
    end
    return ok;
  endfunction : cfg_legal

  if (!cfg_legal(MASTER_ARBITER_INIT_ATTR)) begin : g_chk_m_prio
    $error("Master arbiter init value has a reserved priority or mode");
  end
  if (!cfg_legal(MEMPORT_ARBITER_INIT_ATTR)) begin : g_chk_p_prio
    $error("Memory-port arbiter init value has a reserved priority or mode");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus decode

  localparam int RQ_BIT = cba_pkg::READ_QUEUE_RESET_BIT;
  localparam int WQ_BIT = cba_pkg::WRITE_QUEUE_RESET_BIT;

  logic ack_reg;
  logic ack_next;
  logic take;
  logic wr_take;
  logic rd_take;

  // A held request is taken once; its acknowledge blocks a second take
  assign take = (dcr_read || dcr_write) && !ack_reg;
  assign wr_take = take && dcr_write;
  assign rd_take = take && dcr_read;

  ////////////////////////////////////////////////////////////////////////////////
  // Arbiter configuration words

  logic [31:0] cfg_reg [2];
  logic [31:0] cfg_next [2];
  cba_pkg::cba_cfg_t master_cfg;

  always_comb begin
    cfg_next[0] = cfg_reg[0];
    cfg_next[1] = cfg_reg[1];
    if (wr_take && dcr_addr == cba_pkg::MASTER_ARB_CFG_ADDR) begin
      cfg_next[0] = dcr_wdata & cba_pkg::MASTER_CFG_MASK;
    end
    if (wr_take && dcr_addr == cba_pkg::MEMPORT_ARB_CFG_ADDR) begin
      cfg_next[1] = dcr_wdata & cba_pkg::MEMPORT_CFG_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg[0] <= MASTER_ARBITER_INIT_ATTR;
      cfg_reg[1] <= MEMPORT_ARBITER_INIT_ATTR;
    end else begin
      cfg_reg[0] <= cfg_next[0];
      cfg_reg[1] <= cfg_next[1];
    end
  end

  assign master_cfg = cba_pkg::cba_cfg_t'(cfg_reg[0]);
  assign attr_sync_enable = master_cfg.attr_sync_enable;

  ////////////////////////////////////////////////////////////////////////////////
  // Command queue fault flags

  cba_pkg::cba_fault_t fault_reg;
  cba_pkg::cba_fault_t fault_next;

  always_comb begin
    fault_next = fault_reg;
    if (wr_take && dcr_addr == cba_pkg::MASTER_FAULT_ADDR) begin
      fault_next = fault_reg & ~dcr_wdata[3:0];
    end
    // New events win over a clear in the same cycle
    fault_next = fault_next | master_queue_fault_evt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_reg <= cba_pkg::FAULT_RESET;
    end else begin
      fault_reg <= fault_next;
    end
  end

  assign master_xbar_fifo_int = |fault_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Queue reset pulses

  logic [1:0] qrst_reg;
  logic [1:0] qrst_next;

  always_comb begin
    qrst_next = 2'h0;
    if (wr_take && dcr_addr == cba_pkg::MASTER_RESET_CTRL_ADDR) begin
      qrst_next[RQ_BIT] = dcr_wdata[RQ_BIT];
      qrst_next[WQ_BIT] = dcr_wdata[WQ_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qrst_reg <= 2'h0;
    end else begin
      qrst_reg <= qrst_next;
    end
  end

  assign read_queue_reset = qrst_reg[RQ_BIT];
  assign write_queue_reset = qrst_reg[WQ_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Read return and acknowledge

  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    ack_next = dcr_read || dcr_write;
    if (rd_take) begin
      case (dcr_addr)
        cba_pkg::MASTER_ARB_CFG_ADDR: rdata_next = cfg_reg[0];
        cba_pkg::MEMPORT_ARB_CFG_ADDR: rdata_next = cfg_reg[1];
        cba_pkg::MASTER_FAULT_ADDR: rdata_next = {28'h000_0000, fault_reg};
        cba_pkg::MASTER_RESET_CTRL_ADDR: rdata_next = 32'h0000_0000;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
    end
  end

  assign dcr_rdata = rdata_reg;
  assign dcr_ack = ack_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Arbiters: index 0 bus master, index 1 memory controller port

  logic [4:0] req_all [2];
  logic ready_all [2];
  logic [4:0] gnt_all [2];

  assign req_all[0] = master_req;
  assign req_all[1] = memory_controller_port_req;
  assign ready_all[0] = master_arb_ready;
  assign ready_all[1] = memory_controller_port_arb_ready;
  assign master_gnt = gnt_all[0];
  assign memory_controller_port_gnt = gnt_all[1];

  for (genvar g = 0; g < 2; g++) begin : g_arb
    logic [2:0] lru_reg [5];
    logic [2:0] lru_next [5];
    logic [2:0] last_prio_reg;
    logic [2:0] last_prio_next;
    logic [4:0] gnt_reg;
    logic [4:0] gnt_next;
    cba_pkg::cba_cfg_t cfg;
    cba_pkg::cba_pick_t pick;
    cba_pkg::cba_pick_t pick_lim;

    assign cfg = cba_pkg::cba_cfg_t'(cfg_reg[g]);

    always_comb begin
      logic [2:0] pos;
      pos = 3'h0;
      pick = '0;
      pick_lim = '0;
      last_prio_next = last_prio_reg;
      for (int i = 0; i < cba_pkg::NUM_REQ; i++) begin
        lru_next[i] = lru_reg[i];
      end
      case (cfg.mode)
        cba_pkg::MODE_LRU: begin
          // Front of the list is the least recently granted requester
          for (int i = cba_pkg::NUM_REQ - 1; i >= 0; i--) begin
            if (req_all[g][lru_reg[i]]) begin
              pick.found = 1'b1;
              pick.idx = lru_reg[i];
              pos = 3'(i);
            end
          end
        end
        cba_pkg::MODE_ROUND_ROBIN: begin
          // Walk downward in priority from the last granted level, then wrap
          pick_lim = pick_prio(req_all[g], cfg, last_prio_reg, 1'b1);
          pick = pick_lim.found ? pick_lim : pick_prio(req_all[g], cfg, 3'h0, 1'b0);
        end
        default: begin
          pick = pick_prio(req_all[g], cfg, 3'h0, 1'b0);
        end
      endcase
      gnt_next = 5'h00;
      if (ready_all[g] && pick.found) begin
        gnt_next = onehot(pick.idx);
        last_prio_next = prio_of(cfg, pick.idx);
        for (int i = 0; i < cba_pkg::NUM_REQ - 1; i++) begin
          if (3'(i) >= pos) begin
            lru_next[i] = lru_reg[i + 1];
          end
        end
        lru_next[cba_pkg::NUM_REQ - 1] = pick.idx;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        for (int i = 0; i < cba_pkg::NUM_REQ; i++) begin
          lru_reg[i] <= 3'(i);
        end
        last_prio_reg <= cba_pkg::RR_START;
        gnt_reg <= 5'h00;
      end else begin
        for (int i = 0; i < cba_pkg::NUM_REQ; i++) begin
          lru_reg[i] <= lru_next[i];
        end
        last_prio_reg <= last_prio_next;
        gnt_reg <= gnt_next;
      end
    end

    assign gnt_all[g] = gnt_reg;
  end

endmodule : cba_crossbar_arbiter_config

// ---- cba_pkg.sv ----
// Constants, register map and carrier types for the crossbar arbiter configuration block
package cba_pkg;

  // Register offsets on the device control register bus (word addressed)
  localparam logic [9:0] MASTER_ARB_CFG_ADDR = 10'h023;
  localparam logic [9:0] MASTER_FAULT_ADDR = 10'h024;
  localparam logic [9:0] MASTER_RESET_CTRL_ADDR = 10'h026;
  localparam logic [9:0] MEMPORT_ARB_CFG_ADDR = 10'h028;

  // Requester indices
  localparam int NUM_REQ = 5;
  localparam logic [2:0] REQ_INSTR_READ = 3'h0;
  localparam logic [2:0] REQ_DATA_WRITE = 3'h1;
  localparam logic [2:0] REQ_DATA_READ = 3'h2;
  localparam logic [2:0] REQ_SLAVE_PORT0 = 3'h3;
  localparam logic [2:0] REQ_SLAVE_PORT1 = 3'h4;

  // Arbitration modes
  localparam logic [1:0] MODE_LRU = 2'h0;
  localparam logic [1:0] MODE_ROUND_ROBIN = 2'h1;
  localparam logic [1:0] MODE_FIXED = 2'h2;

  // Highest legal priority code, and round-robin pointer start value
  localparam logic [2:0] PRIO_MAX = 3'h4;
  localparam logic [2:0] RR_START = 3'h7;

  // Configuration word reset values and writable-bit masks
  localparam logic [31:0] ARB_CFG_DEFAULT = 32'h0043_2010;
  localparam logic [31:0] MASTER_CFG_MASK = 32'h0077_7777;
  localparam logic [31:0] MEMPORT_CFG_MASK = 32'h0077_7773;

  // Fault flag reset value, queue reset bit positions
  localparam logic [3:0] FAULT_RESET = 4'h0;
  localparam int READ_QUEUE_RESET_BIT = 1;
  localparam int WRITE_QUEUE_RESET_BIT = 0;

  // Configuration word layout, bit 31 is the high end of the word
  typedef struct packed {
    logic [8:0] rsv0;
    logic [2:0] instr_read_prio;
    logic rsv1;
    logic [2:0] data_write_prio;
    logic rsv2;
    logic [2:0] data_read_prio;
    logic rsv3;
    logic [2:0] slave_port1_prio;
    logic rsv4;
    logic [2:0] slave_port0_prio;
    logic rsv5;
    logic attr_sync_enable;
    logic [1:0] mode;
  } cba_cfg_t;

  // Command queue fault events and flags, low four bits of the status word
  typedef struct packed {
    logic queue_a_overflow;
    logic queue_a_underflow;
    logic queue_b_overflow;
    logic queue_b_underflow;
  } cba_fault_t;

  // Arbitration pick result
  typedef struct packed {
    logic found;
    logic [2:0] idx;
  } cba_pick_t;

endpackage : cba_pkg

// ---- cba_req_model.sv ----
// Requester model: holds requests until granted
`timescale 1ns/1ns
module cba_req_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic hold,
  input wire logic [4:0] want,
  input wire logic [4:0] gnt,
  output logic [4:0] req
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req <= 5'h00;
    end else if (load) begin
      req <= want;
    end else if (!hold) begin
      req <= req & ~gnt;
    end
  end
endmodule : cba_req_model

// ---- tb_top.sv ----
// Self-checking bench for the crossbar arbiter configuration block
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic rdy = 1'b0;
  logic hold = 1'b0;
  logic [1:0] ld = 2'h0;
  logic [4:0] want = 5'h00;
  logic [9:0] adr = 10'h000;
  logic [31:0] wd = 32'h0;
  cba_pkg::cba_fault_t fevt = 4'h0;
  logic [31:0] rdat, rv;
  logic [4:0] mreq, mgnt, preq, pgnt;
  logic [1:0] qr;
  logic ack, sync, rqr, wqr, fint;
  int err_count = 0;
  int samples_checked = 0;
  cba_crossbar_arbiter_config dut (.clk(clk), .rst_n(rst_n), .dcr_read(rd), .dcr_write(wr),
    .dcr_addr(adr), .dcr_wdata(wd), .dcr_rdata(rdat), .dcr_ack(ack), .master_req(mreq),
    .master_arb_ready(rdy), .master_gnt(mgnt), .attr_sync_enable(sync),
    .memory_controller_port_req(preq), .memory_controller_port_arb_ready(rdy),
    .memory_controller_port_gnt(pgnt), .master_queue_fault_evt(fevt),
    .read_queue_reset(rqr), .write_queue_reset(wqr), .master_xbar_fifo_int(fint));
  cba_req_model u_mreq (.clk(clk), .rst_n(rst_n), .load(ld[1]), .hold(hold), .want(want),
    .gnt(mgnt), .req(mreq));
  cba_req_model u_preq (.clk(clk), .rst_n(rst_n), .load(ld[0]), .hold(hold), .want(want),
    .gnt(pgnt), .req(preq));
  initial forever #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    wr = w;
    rd = !w;
    adr = a;
    wd = d;
    while (ack !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 8) begin
        err_count++;
        end_sim();
      end
    end
    rv = rdat;
    qr = {rqr, wqr};
    wr = 1'b0;
    rd = 1'b0;
    @(negedge clk);
  endtask : bus
  task automatic rc(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rv, e);
  endtask : rc
  task automatic arb(input logic m, input logic [4:0] w, input logic [17:0] seq, input int n);
    @(negedge clk);
    ld = {m, !m};
    want = w;
    @(negedge clk);
    ld = 2'h0;
    for (int k = 0; k < n; k++) begin
      rdy = 1'b1;
      @(negedge clk);
      rdy = 1'b0;
      cmp({27'h0, m ? mgnt : pgnt}, 32'h1 << seq[3*k +: 3]);
      @(negedge clk);
    end
  endtask : arb
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rc(cba_pkg::MASTER_ARB_CFG_ADDR, 32'h0043_2010);
    rc(cba_pkg::MEMPORT_ARB_CFG_ADDR, 32'h0043_2010);
    rc(cba_pkg::MASTER_FAULT_ADDR, 32'h0);
    rc(10'h3FF, 32'h0);
    cmp({30'h0, sync, fint}, 32'h0);
  endtask : t_reset
  task automatic t_lru();
    arb(1'b0, 5'h12, 18'h00021, 2);
    arb(1'b0, 5'h1F, 18'h042D0, 5);
  endtask : t_lru
  task automatic t_cfg();
    bus(1'b1, cba_pkg::MASTER_ARB_CFG_ADDR, 32'hFF89_ABCE);
    rc(cba_pkg::MASTER_ARB_CFG_ADDR, 32'h0001_2346);
    cmp({31'h0, sync}, 32'h1);
    bus(1'b1, cba_pkg::MEMPORT_ARB_CFG_ADDR, 32'hFF89_ABCE);
    rc(cba_pkg::MEMPORT_ARB_CFG_ADDR, 32'h0001_2342);
    bus(1'b1, 10'h3FF, 32'h0000_1111);
    rc(10'h3FF, 32'h0);
  endtask : t_cfg
  task automatic t_fixed();
    arb(1'b1, 5'h1F, 18'h002A3, 5);
  endtask : t_fixed
  task automatic t_rr();
    bus(1'b1, cba_pkg::MASTER_ARB_CFG_ADDR, 32'h0001_2345);
    hold = 1'b1;
    arb(1'b1, 5'h1F, 18'h182A3, 6);
    hold = 1'b0;
  endtask : t_rr
  task automatic t_fault();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      fevt = cba_pkg::cba_fault_t'(4'h1 << i);
      @(negedge clk);
      fevt = 4'h0;
      cmp({31'h0, fint}, 32'h1);
      bus(1'b1, cba_pkg::MASTER_FAULT_ADDR, 32'h0);
      rc(cba_pkg::MASTER_FAULT_ADDR, 32'h1 << i);
      bus(1'b1, cba_pkg::MASTER_FAULT_ADDR, 32'h1 << i);
      rc(cba_pkg::MASTER_FAULT_ADDR, 32'h0);
      cmp({31'h0, fint}, 32'h0);
    end
  endtask : t_fault
  task automatic t_race();
    fork
      bus(1'b1, cba_pkg::MASTER_FAULT_ADDR, 32'hF);
      begin
        @(negedge clk);
        fevt = 4'h8;
        @(negedge clk);
        fevt = 4'h0;
      end
    join
    rc(cba_pkg::MASTER_FAULT_ADDR, 32'h8);
    cmp({31'h0, fint}, 32'h1);
    bus(1'b1, cba_pkg::MASTER_FAULT_ADDR, 32'h8);
    rc(cba_pkg::MASTER_FAULT_ADDR, 32'h0);
  endtask : t_race
  task automatic t_qreset();
    bus(1'b1, cba_pkg::MASTER_RESET_CTRL_ADDR, 32'h3);
    cmp({30'h0, qr}, 32'h3);
    bus(1'b1, cba_pkg::MASTER_RESET_CTRL_ADDR, 32'h1);
    cmp({30'h0, qr}, 32'h1);
    rc(cba_pkg::MASTER_RESET_CTRL_ADDR, 32'h0);
  endtask : t_qreset
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_lru();
    t_cfg();
    t_fixed();
    t_rr();
    t_fault();
    t_race();
    t_qreset();
    end_sim();
  end
endmodule : tb_top
